/* File: rtl/pic_pkg.sv */
// Package of constants for the prioritized interrupt controller
package pic_pkg;
   // Number of interrupt sources
   localparam int NUM_SRC = 64;
   // Width of a priority level (sixteen levels)
   localparam int LVL_W = 4;
   // Width of a source number
   localparam int SRC_W = 6;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_MASKLVL = 8'h04;
   localparam logic [7:0] OFF_ENNUM = 8'h08;
   localparam logic [7:0] OFF_DISNUM = 8'h0C;
   localparam logic [7:0] OFF_ENLO = 8'h10;
   localparam logic [7:0] OFF_ENHI = 8'h14;
   localparam logic [7:0] OFF_TYPELO = 8'h18;
   localparam logic [7:0] OFF_TYPEHI = 8'h1C;
   localparam logic [7:0] OFF_PRIO0 = 8'h20;
   localparam logic [7:0] OFF_PRIO7 = 8'h3C;
   localparam logic [7:0] OFF_VECTOR = 8'h40;
   localparam logic [7:0] OFF_PENDLO = 8'h44;
   localparam logic [7:0] OFF_PENDHI = 8'h48;
   localparam logic [7:0] OFF_IRQSTAT = 8'h4C;
   localparam logic [7:0] OFF_IRQMASK = 8'h50;
   // Sources covered by one priority register
   localparam int SRC_PER_PRIO = 8;
   // Control register fields
   localparam int CTRL_BIT_NFORCE_OFF = 0;
   localparam int CTRL_BIT_FFORCE_OFF = 1;
   // Status event bit positions
   localparam int EV_BIT_PRIV_ERR = 0;
   localparam int EV_BIT_NEW_FAST = 1;
   localparam int EV_BIT_NEW_NORM = 2;
   localparam int EV_W = 3;
   // Reset values
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [LVL_W-1:0] RST_MASKLVL = 4'hF;
   // Vector register: valid flags positions
   localparam int VEC_BIT_FVALID = 31;
   localparam int VEC_BIT_NVALID = 30;
endpackage : pic_pkg

/* File: rtl/pic_ctrl.sv */
// Prioritized interrupt controller with APB register port
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
// Summary of operation
// - Per-source enable via bulk or number registers
// - Enabled asserted source raises fast or normal
// - Only supervisor-privileged accesses are accepted
// - Fast first, then level, then source number
// - Sixteen levels, zero lowest, larger higher
// - Eight writable priority registers cover all sources
// - Software mask threshold suppresses normal requests
// Sixty-four level-sensitive sources are qualified by their enables, split
// into fast and normal by their type bits, and arbitrated every cycle. The
// two request lines are registered, so they follow a source by one edge.
// A small event block reports new requests and privilege faults on irq_out.
module pic_ctrl #(
   parameter int NUM_SRC = pic_pkg::NUM_SRC
)(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [NUM_SRC-1:0] irq_src,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [2:0] pprot,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic core_fiq_req,
   output logic core_nirq_req,
   output logic irq_out
);

   // Short local names for the level and source-number widths
   localparam int LW = pic_pkg::LVL_W; // Bits of one priority level
   localparam int SW = pic_pkg::SRC_W; // Bits of one source number

   // Register state
   // Everything software can set lives here; all of it is cleared by
   // reset except the mask level, which starts fully closed so no normal
   // request reaches the core before software has set up the levels.
   // The level array is a plain flop bank of one nibble per source.
   logic [NUM_SRC-1:0] src_enable; // Per-source enables
   logic [NUM_SRC-1:0] src_fast; // 1 = fast type
   logic [LW-1:0] src_level [NUM_SRC]; // Per-source priority level
   logic [LW-1:0] mask_level; // Normal mask threshold
   logic [1:0] ctrl; // Force-off bits
   logic [pic_pkg::EV_W-1:0] ev_status; // Sticky events
   logic [pic_pkg::EV_W-1:0] ev_mask; // Event interrupt mask

   // Bus decode helpers
   // All of them are combinational from the bus inputs of this cycle
   logic access; // Access phase cycle
   logic priv_ok; // Supervisor flag present
   logic wr_ok; // Accepted write
   logic rd_ok; // Accepted read
   logic addr_hit; // Address maps to a register

   // Arbitration results
   // Combinational winners, recomputed every cycle from the pending set
   logic [NUM_SRC-1:0] pending; // Enabled and asserted
   logic fast_any; // Some fast source pending
   logic [SW-1:0] fast_id; // Winning fast source
   logic norm_any; // Some normal source pending
   logic [SW-1:0] norm_id; // Winning normal source
   logic [LW-1:0] norm_lvl; // Level of the normal winner
   logic fast_any_q; // Fast pending, one cycle late
   logic norm_any_q; // Normal pending, one cycle late

   // Address decode shared by read and write
   // Only whole aligned words up to the last register respond
   function automatic logic is_mapped(input logic [7:0] a);
      logic r;
      r = 1'b0;
      if (a[1:0] == 2'h0 && a <= pic_pkg::OFF_IRQMASK)
      begin
         r = 1'b1;
      end
      return r;
   endfunction : is_mapped

   // Range check for the priority bank
   function automatic logic is_prio(input logic [7:0] a);
      return (a >= pic_pkg::OFF_PRIO0) && (a <= pic_pkg::OFF_PRIO7);
   endfunction : is_prio

   // Source number held in nibble j of priority register k; register 0
   // carries the top eight sources, so the index runs downwards with k
   function automatic int prio_src(input logic [2:0] k, input int j);
      return NUM_SRC - 1 - pic_pkg::SRC_PER_PRIO * int'(k)
         - (pic_pkg::SRC_PER_PRIO - 1 - j);
   endfunction : prio_src

   // Zero-wait slave: answer in the access cycle
   // Only pprot bit 0 matters here; the other protection bits are taken
   // as they come, since nothing in this block depends on them.
   // pready is constant: the register file never needs a wait state.
   assign access = psel & penable;
   assign priv_ok = pprot[0];
   assign addr_hit = is_mapped(paddr);
   assign wr_ok = access & pwrite & priv_ok & addr_hit;
   assign rd_ok = access & ~pwrite & priv_ok & addr_hit;
   assign pready = 1'b1;
   // User-mode or unmapped accesses are refused with an error
   assign pslverr = access & (~priv_ok | ~addr_hit);

   // Enables: bulk words plus set/clear by number
   // Number writes touch one bit only, so two software users can enable
   // and disable their own lines without a read-modify-write race.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         // All sources start disabled
         src_enable <= '0;
      end
      else if (wr_ok)
      begin
         // Bulk words first, then the single-source forms
         case (paddr)
            pic_pkg::OFF_ENLO: src_enable[31:0] <= pwdata;
            pic_pkg::OFF_ENHI: src_enable[63:32] <= pwdata;
            pic_pkg::OFF_ENNUM: src_enable[pwdata[SW-1:0]] <= 1'b1;
            pic_pkg::OFF_DISNUM: src_enable[pwdata[SW-1:0]] <= 1'b0;
            default: src_enable <= src_enable;
         endcase
      end
   end

   // Type selection per source
   // A type change takes effect on the next arbitration, even for a
   // source that is already pending.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         // All sources start as normal
         src_fast <= '0;
      end
      else if (wr_ok && paddr == pic_pkg::OFF_TYPELO)
      begin
         src_fast[31:0] <= pwdata;
      end
      else if (wr_ok && paddr == pic_pkg::OFF_TYPEHI)
      begin
         src_fast[63:32] <= pwdata;
      end
   end

   // Eight priority registers, eight 4-bit levels each
   // A write replaces all eight nibbles of the register at once.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         // All levels start at zero, the lowest
         for (int i = 0; i < NUM_SRC; i++)
         begin
            src_level[i] <= '0;
         end
      end
      else if (wr_ok && is_prio(paddr))
      begin
         for (int j = 0; j < pic_pkg::SRC_PER_PRIO; j++)
         begin
            // Register 0 holds the highest eight sources
            src_level[prio_src(paddr[4:2], j)] <= pwdata[LW*j +: LW];
         end
      end
   end

   // Mask threshold and control bits
   // The control bits let software silence either request line at once
   // without touching any per-source enable.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         mask_level <= pic_pkg::RST_MASKLVL;
         ctrl <= 2'h0;
         ev_mask <= '0;
      end
      else if (wr_ok)
      begin
         case (paddr)
            pic_pkg::OFF_MASKLVL: mask_level <= pwdata[LW-1:0];
            pic_pkg::OFF_CTRL: ctrl <= pwdata[1:0];
            pic_pkg::OFF_IRQMASK: ev_mask <= pwdata[pic_pkg::EV_W-1:0];
            default: ctrl <= ctrl;
         endcase
      end
   end

   // Source qualification
   assign pending = irq_src & src_enable;

   // Arbitration: ascending scan so the highest number wins ties
   // Fast sources are kept out of the level race; the scan is a long
   // chain of compares, accepted at this modest clock rate.
   always_comb
   begin
      fast_any = 1'b0;
      fast_id = '0;
      norm_any = 1'b0;
      norm_id = '0;
      norm_lvl = '0;
      for (int i = 0; i < NUM_SRC; i++)
      begin
         // Fast: the last hit of the ascending scan is the highest number
         if (pending[i] && src_fast[i])
         begin
            fast_any = 1'b1;
            fast_id = SW'(i);
         end
         else if (pending[i] && (!norm_any || src_level[i] >= norm_lvl))
         begin
            // Equal level replaces: the higher number wins
            norm_any = 1'b1;
            norm_id = SW'(i);
            norm_lvl = src_level[i];
         end
      end
   end

   // Requests to the core, registered
   // The flop costs one cycle of latency but keeps the long arbitration
   // path away from the core's input timing.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         // No request may reach the core while reset is held
         core_fiq_req <= 1'b0;
         core_nirq_req <= 1'b0;
      end
      else
      begin
         // Fast ignores the level mask
         core_fiq_req <= fast_any & ~ctrl[pic_pkg::CTRL_BIT_FFORCE_OFF];
         // Normal must beat the threshold strictly
         core_nirq_req <= norm_any & (norm_lvl > mask_level)
            & ~ctrl[pic_pkg::CTRL_BIT_NFORCE_OFF];
      end
   end

   // Edge tracking for new-request events
   // A new-request event is the rise of any-pending, so a second source
   // joining an already pending set raises no further event.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         // Start idle so release raises no event unless a source is live
         fast_any_q <= 1'b0;
         norm_any_q <= 1'b0;
      end
      else
      begin
         fast_any_q <= fast_any;
         norm_any_q <= norm_any;
      end
   end

   // Sticky event status; an event in the read cycle survives
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         ev_status <= '0;
      end
      else
      begin
         // Clear only what the read returned: prdata was loaded in the
         // setup cycle, so an event arriving between setup and access
         // is kept for the next read instead of being lost
         if (rd_ok && paddr == pic_pkg::OFF_IRQSTAT)
         begin
            ev_status <= ev_status & ~prdata[pic_pkg::EV_W-1:0];
         end
         // Sets follow the clear so that a same-cycle event wins
         // Privilege faults are recorded though the access has no effect
         if (access && !priv_ok)
         begin
            ev_status[pic_pkg::EV_BIT_PRIV_ERR] <= 1'b1;
         end
         if (fast_any && !fast_any_q)
         begin
            ev_status[pic_pkg::EV_BIT_NEW_FAST] <= 1'b1;
         end
         if (norm_any && !norm_any_q)
         begin
            ev_status[pic_pkg::EV_BIT_NEW_NORM] <= 1'b1;
         end
      end
   end

   // Level interrupt while any unmasked event is set
   // Built from flops only, so it cannot glitch with the bus inputs
   assign irq_out = |(ev_status & ev_mask);

   // Read data mux, loaded in the setup cycle so it stands in the access
   // cycle; the setup phase pays for a flop output at no wait-state cost.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         prdata <= pic_pkg::RST_ZERO;
      end
      else if (psel && !penable && !pwrite)
      begin
         // User-mode reads, and unmapped reads outside the priority bank, return zero
         prdata <= pic_pkg::RST_ZERO;
         if (!priv_ok)
         begin
            // A user-mode read must not leak configuration
            prdata <= pic_pkg::RST_ZERO;
         end
         else if (is_prio(paddr))
         begin
            for (int j = 0; j < pic_pkg::SRC_PER_PRIO; j++)
            begin
               prdata[LW*j +: LW] <= src_level[prio_src(paddr[4:2], j)];
            end
         end
         else
         begin
            case (paddr)
               pic_pkg::OFF_CTRL: prdata <= {30'h0, ctrl};
               pic_pkg::OFF_MASKLVL: prdata <= {28'h0, mask_level};
               pic_pkg::OFF_ENLO: prdata <= src_enable[31:0];
               pic_pkg::OFF_ENHI: prdata <= src_enable[63:32];
               pic_pkg::OFF_TYPELO: prdata <= src_fast[31:0];
               pic_pkg::OFF_TYPEHI: prdata <= src_fast[63:32];
               // Vector word: both valid flags on top, then the two winners
               pic_pkg::OFF_VECTOR: prdata <= {fast_any, norm_any, 6'h0, 2'h0, fast_id,
                  4'h0, norm_lvl, 2'h0, norm_id};
               pic_pkg::OFF_PENDLO: prdata <= pending[31:0];
               pic_pkg::OFF_PENDHI: prdata <= pending[63:32];
               pic_pkg::OFF_IRQSTAT: prdata <= {29'h0, ev_status};
               pic_pkg::OFF_IRQMASK: prdata <= {29'h0, ev_mask};
               default: prdata <= pic_pkg::RST_ZERO;
            endcase
         end
      end
   end

endmodule : pic_ctrl

/* File: testbench/pic_checker.sv */
// Port assertions for the interrupt controller
`timescale 1ns/100ps
module pic_checker #(parameter int NUM_SRC = 64)(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [NUM_SRC-1:0] irq_src,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [2:0] pprot,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic core_fiq_req,
   input wire logic core_nirq_req,
   input wire logic irq_out
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // Access phase, and a word inside the map
   wire acc = psel && penable;
   wire hit = paddr <= 8'h50 && paddr[1:0] == 2'h0;
   property p_rdy; acc |-> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready");
   property p_user; acc && !pprot[0] |-> pslverr; endproperty
   a_user: assert property (p_user) else $error("user accepted");
   property p_unmap; acc && !hit |-> pslverr; endproperty
   a_unmap: assert property (p_unmap) else $error("hole accepted");
   property p_ok; acc && pprot[0] && hit |-> !pslverr; endproperty
   a_ok: assert property (p_ok) else $error("good access refused");
   property p_idle; irq_src == '0 |=> !core_fiq_req && !core_nirq_req; endproperty
   a_idle: assert property (p_idle) else $error("request from nothing");
   property p_cause; $rose(core_fiq_req) |-> $past(irq_src) != '0; endproperty
   a_cause: assert property (p_cause) else $error("fast without source");
   // Two edges: register write, then request register
   property p_maskf; acc && pwrite && pprot[0] && paddr == pic_pkg::OFF_MASKLVL
      && pwdata[3:0] == 4'hF |-> ##2 !core_nirq_req; endproperty
   a_maskf: assert property (p_maskf) else $error("mask ignored");
   property p_rst; disable iff (1'b0) reset |=> !core_fiq_req && !core_nirq_req && !irq_out;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs live in reset");
   property p_usrd; acc && !pwrite && !pprot[0] |-> prdata == '0; endproperty
   a_usrd: assert property (p_usrd) else $error("user read leaked");
   c_err: cover property (acc && pslverr);
   c_fiq: cover property ($rose(core_fiq_req));
   c_nirq: cover property ($rose(core_nirq_req));
   c_irq: cover property ($rose(irq_out));
endmodule : pic_checker
bind pic_ctrl pic_checker #(.NUM_SRC(NUM_SRC)) pic_checker_inst (.sys_clk, .reset, .irq_src,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pprot, .prdata, .pready, .pslverr,
   .core_fiq_req, .core_nirq_req, .irq_out);

/* File: testbench/pic_core_model.sv */
// Core-side model counting fast request entries
`timescale 1ns/100ps
module pic_core_model (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic core_fiq_req,
   output int fiq_seen
);
   logic prev;
   // Count each new fast entry, not its length
   always_ff @(posedge sys_clk)
   begin
      prev <= core_fiq_req;
      if (reset)
         fiq_seen <= 0;
      else if (core_fiq_req && !prev)
         fiq_seen <= fiq_seen + 1;
   end
endmodule : pic_core_model

/* File: testbench/pic_ctrl_tb.sv */
// Self-checking bench for the interrupt controller
`timescale 1ns/100ps
module pic_ctrl_tb;
   logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, core_fiq_req, core_nirq_req;
   logic irq_out;
   logic [63:0] irq_src;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, v;
   logic [2:0] pprot;
   logic [32:0] exp_q[$], e;
   int mismatches, tests_run, fiq_seen, s1, s2, l1, l2, l;
   pic_ctrl pic_ctrl_inst (.sys_clk, .reset, .irq_src, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pprot, .prdata, .pready, .pslverr, .core_fiq_req, .core_nirq_req, .irq_out);
   pic_core_model pic_core_model_inst (.sys_clk, .reset, .core_fiq_req, .fiq_seen);
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task final_report;
      $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report
   task ck(input string n, input logic [31:0] x, input logic [31:0] g);
      tests_run++;
      if (g !== x)
      begin
         mismatches++;
         $display("[ERR] %s exp %h got %h", n, x, g);
      end
   endtask : ck
   // Note the answer, then hold the request until ready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic pr,
      input logic [32:0] x);
      exp_q.push_back(x);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pprot <= {2'h0, pr};
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b1, 33'h0);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0, 1'b1, {1'b0, x});
   endtask : rd
   // Let the registered request follow
   task st;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask : st
   // Retire the oldest note at each access phase
   always @(posedge sys_clk)
   begin
      if (psel && penable && pready)
      begin
         e = exp_q.pop_front();
         tests_run++;
         if (e[32] ? pslverr !== 1'b1 : pslverr !== 1'b0 || (!pwrite && prdata !== e[31:0]))
         begin
            mismatches++;
            $display("[ERR] apb %h exp %h got %h", paddr, e, {pslverr, prdata});
         end
      end
   end
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, pprot, irq_src} = '0;
      reset = 1'b1;
      v = $urandom(32'h2507);
      repeat (6) @(posedge sys_clk);
      reset <= 1'b0;
      rd(pic_pkg::OFF_MASKLVL, 32'hF);
      apb(1'b1, pic_pkg::OFF_ENLO, 32'hFFFF_FFFF, 1'b0, 33'h1_0000_0000);
      apb(1'b0, pic_pkg::OFF_MASKLVL, 32'h0, 1'b0, 33'h1_0000_0000);
      rd(pic_pkg::OFF_ENLO, 32'h0);
      apb(1'b0, 8'h54, 32'h0, 1'b1, 33'h1_0000_0000);
      rd(pic_pkg::OFF_IRQSTAT, 32'h1);
      rd(pic_pkg::OFF_IRQSTAT, 32'h0);
      for (l = 0; l < 8; l++)
      begin
         v = $urandom;
         wr(8'(pic_pkg::OFF_PRIO0 + 4 * l), v);
         rd(8'(pic_pkg::OFF_PRIO0 + 4 * l), v);
      end
      s1 = $urandom_range(31, 0);
      s2 = $urandom_range(63, 32);
      l1 = $urandom_range(15, 1);
      l2 = $urandom_range(15, 1);
      l = (l2 >= l1) ? l2 : l1;
      wr(pic_pkg::OFF_ENNUM, s1);
      wr(pic_pkg::OFF_ENHI, 32'h1 << (s2 - 32));
      wr(8'(pic_pkg::OFF_PRIO0 + 4 * (7 - s1 / 8)), l1 << 4 * (s1 % 8));
      wr(8'(pic_pkg::OFF_PRIO0 + 4 * (7 - s2 / 8)), l2 << 4 * (s2 % 8));
      // Neighbour of s1 stays disabled
      irq_src <= (64'h1 << s1) | (64'h1 << s2) | (64'h1 << (s1 ^ 1));
      wr(pic_pkg::OFF_MASKLVL, 32'h0);
      st;
      ck("nirq", 1, core_nirq_req);
      ck("fiq", 0, core_fiq_req);
      rd(pic_pkg::OFF_PENDLO, 32'h1 << s1);
      rd(pic_pkg::OFF_PENDHI, 32'h1 << (s2 - 32));
      rd(pic_pkg::OFF_VECTOR, 32'h4000_0000 | l << 8 | ((l2 >= l1) ? s2 : s1));
      wr(pic_pkg::OFF_MASKLVL, l);
      st;
      ck("nirq", 0, core_nirq_req);
      wr(pic_pkg::OFF_MASKLVL, l - 1);
      st;
      ck("nirq", 1, core_nirq_req);
      // Control bit 0 silences the normal line alone
      wr(pic_pkg::OFF_CTRL, 32'h1);
      st;
      ck("nirq", 0, core_nirq_req);
      wr(pic_pkg::OFF_CTRL, 32'h0);
      wr(pic_pkg::OFF_TYPELO, 32'h1 << s1);
      wr(pic_pkg::OFF_MASKLVL, 32'h0);
      st;
      ck("fiq", 1, core_fiq_req);
      rd(pic_pkg::OFF_VECTOR, 32'hC000_0000 | s1 << 16 | l2 << 8 | s2);
      wr(pic_pkg::OFF_MASKLVL, 32'hF);
      st;
      ck("fiq", 1, core_fiq_req);
      ck("nirq", 0, core_nirq_req);
      // Control bit 1 silences the fast line; the core sees a second entry
      wr(pic_pkg::OFF_CTRL, 32'h2);
      st;
      ck("fiq", 0, core_fiq_req);
      rd(pic_pkg::OFF_CTRL, 32'h2);
      wr(pic_pkg::OFF_CTRL, 32'h0);
      st;
      ck("fiq", 1, core_fiq_req);
      wr(pic_pkg::OFF_DISNUM, s1);
      st;
      ck("fiq", 0, core_fiq_req);
      ck("irq", 0, irq_out);
      wr(pic_pkg::OFF_IRQMASK, 32'h6);
      st;
      ck("irq", 1, irq_out);
      rd(pic_pkg::OFF_IRQSTAT, 32'h6);
      st;
      ck("irq", 0, irq_out);
      ck("taken", 2, fiq_seen);
      final_report;
   end
   // Hang guard, far beyond the fewer than two hundred cycles used
   initial
   begin
      #200us;
      mismatches++;
      final_report;
   end
endmodule : pic_ctrl_tb
